// >>> hw/mra_defs.svh
`ifndef MRA_DEFS_SVH
`define MRA_DEFS_SVH
`define MRA_DW            32
`define MRA_AW            22
`define MRA_SW            4
`define MRA_NBLK          3
// Word address map: bit 21 high routes to the application blocks
`define MRA_APP_BIT       21
`define MRA_BLK_HI        20
`define MRA_BLK_LO        19
`define MRA_CSR_IDX_W     4
`define MRA_CSR_DEPTH     16
`define MRA_CAPT_IDX      4'hf
`define MRA_EVT_IDX       4'he
`define MRA_MASK_IDX      4'hd
// Access timeout, 2.56 us at 100 MHz
`define MRA_TMO_NS        2560
`define MRA_CLK_NS        10
`define MRA_TMO_CYC       (`MRA_TMO_NS / `MRA_CLK_NS)
`define MRA_TMO_W         9
`define MRA_ONE_LOW       1'b0
`define MRA_IDLE_HIGH     1'b1
`endif

// >>> hw/mra_pkg.sv
`default_nettype none
package mra_pkg;
  typedef enum logic [2:0] {
    MRA_IDLE  = 3'b000,
    MRA_CSR   = 3'b001,
    MRA_APP   = 3'b010,
    MRA_DONE  = 3'b011,
    MRA_HOLD  = 3'b100
  } mra_state_t;
  typedef logic [1:0] mra_blk_t;
endpackage
`default_nettype wire

// >>> hw/mra_app_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "mra_defs.svh"
interface mra_app_if;
  logic [`MRA_AW-1:0] addr;
  logic [`MRA_DW-1:0] wdata;
  logic [`MRA_SW-1:0] wr_low;
  logic               rd_low;
  logic               sel_low;
  logic [`MRA_DW-1:0] rdata;
  logic               ready;
  modport master (output addr, wdata, wr_low, rd_low, sel_low, input rdata, ready);
  modport mux (input addr, wdata, wr_low, rd_low, sel_low, output rdata, ready);
endinterface
`default_nettype wire

// >>> hw/mra_app_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "mra_defs.svh"
module mra_app_mux
(
  // Clock
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire logic                   clk_en,
  // Master side
  mra_app_if.mux                      m,
  // Shared outbound pins
  output logic [`MRA_AW-1:0]          app_addr,
  output logic [`MRA_DW-1:0]          app_wdata,
  output logic [`MRA_SW-1:0]          app_wr_low,
  output logic                        app_rd_low,
  output logic                        app_sel_low,
  // Per-block returns
  input  wire logic [`MRA_DW-1:0]     appblk0_rdata_in,
  input  wire logic [`MRA_DW-1:0]     appblk1_rdata_in,
  input  wire logic [`MRA_DW-1:0]     appblk2_rdata_in,
  input  wire logic                   appblk0_ready_low,
  input  wire logic                   appblk1_ready_low,
  input  wire logic                   appblk2_ready_low
);
  mra_pkg::mra_blk_t blk;
  logic [`MRA_DW-1:0] rdata_d;
  logic [`MRA_DW-1:0] rdata_q;
  logic               rdy_d;
  logic               rdy_q;

  // Shared strobes go straight out
  assign app_addr    = m.addr;
  assign app_wdata   = m.wdata;
  assign app_wr_low  = m.wr_low;
  assign app_rd_low  = m.rd_low;
  assign app_sel_low = m.sel_low;
  assign blk         = m.addr[`MRA_BLK_HI:`MRA_BLK_LO];

  always_comb
  begin
    rdata_d = rdata_q;
    rdy_d   = 1'b0;
    // Block chosen by address; code 3 never answers and ends in timeout
    case (blk)
      2'h0:
      begin
        rdy_d   = ~appblk0_ready_low & ~m.sel_low;
        rdata_d = appblk0_rdata_in;
      end
      2'h1:
      begin
        rdy_d   = ~appblk1_ready_low & ~m.sel_low;
        rdata_d = appblk1_rdata_in;
      end
      2'h2:
      begin
        rdy_d   = ~appblk2_ready_low & ~m.sel_low;
        rdata_d = appblk2_rdata_in;
      end
      default:
      begin
        rdy_d   = 1'b0;
        rdata_d = rdata_q;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rdata_q <= '0;
      rdy_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_q <= rdata_d;
      rdy_q   <= rdy_d;
    end
  end

  assign m.rdata = rdata_q;
  assign m.ready = rdy_q;
endmodule
`default_nettype wire

// >>> hw/mra_csr_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "mra_defs.svh"
module mra_csr_bank
(
  // Clock
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  // Access
  input  wire logic                       wr_en,
  input  wire logic [`MRA_CSR_IDX_W-1:0]  idx,
  input  wire logic [`MRA_SW-1:0]         byte_en,
  input  wire logic [`MRA_DW-1:0]         wdata,
  output logic [`MRA_DW-1:0]              rdata,
  // Capture and event side
  input  wire logic                       capt_en,
  input  wire logic [`MRA_DW-1:0]         capt_data,
  input  wire logic [`MRA_DW-1:0]         evt_set,
  output logic [`MRA_DW-1:0]              evt_pend
);
  logic [`MRA_DW-1:0] mem_q [`MRA_CSR_DEPTH];
  logic [`MRA_DW-1:0] mem_d [`MRA_CSR_DEPTH];

  function automatic logic [`MRA_DW-1:0] merge(input logic [`MRA_DW-1:0] o,
                                               input logic [`MRA_DW-1:0] n,
                                               input logic [`MRA_SW-1:0] be);
    logic [`MRA_DW-1:0] r;
    r = o;
    for (int b = 0; b < `MRA_SW; b++)
      if (be[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  always_comb
  begin
    for (int i = 0; i < `MRA_CSR_DEPTH; i++)
      mem_d[i] = mem_q[i];
    if (wr_en)
      mem_d[idx] = merge(mem_q[idx], wdata, byte_en);
    if (wr_en && idx == `MRA_EVT_IDX)
      mem_d[`MRA_EVT_IDX] = mem_q[`MRA_EVT_IDX] & ~(wdata & merge('0, '1, byte_en));
    // Set beats clear
    mem_d[`MRA_EVT_IDX] = mem_d[`MRA_EVT_IDX] | evt_set;
    if (capt_en)
      mem_d[`MRA_CAPT_IDX] = capt_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < `MRA_CSR_DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < `MRA_CSR_DEPTH; i++)
        mem_q[i] <= mem_d[i];
    end
  end

  assign rdata    = mem_q[idx];
  assign evt_pend = mem_q[`MRA_EVT_IDX] & mem_q[`MRA_MASK_IDX];
endmodule
`default_nettype wire

// >>> hw/mra_mgmt_ports.sv
`timescale 1ns/10ps
`default_nettype none
`include "mra_defs.svh"
module mra_mgmt_ports
(
  // Clock
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                clk_en,
  // Inbound host port
  input  wire logic [`MRA_DW-1:0]  host_wdata_in,
  output logic [`MRA_DW-1:0]       host_rdata_out,
  input  wire logic [`MRA_AW-1:0]  host_addr_in,
  input  wire logic                host_sel_low,
  input  wire logic [`MRA_SW-1:0]  host_wr_low,
  input  wire logic                host_rd_low,
  output logic                     host_ready_low,
  output logic                     host_irq_low,
  output logic                     host_timeout_low,
  // Error capture
  input  wire logic [`MRA_DW-1:0]  capt_data_in,
  input  wire logic                capt_req_low,
  output logic                     capt_ack_low,
  // Core events, one cycle high each
  input  wire logic [`MRA_DW-1:0]  core_event,
  // Outbound application port
  output logic [`MRA_AW-1:0]       app_addr,
  output logic [`MRA_DW-1:0]       app_wdata,
  output logic [`MRA_SW-1:0]       app_wr_low,
  output logic                     app_rd_low,
  output logic                     app_sel_low,
  input  wire logic [`MRA_DW-1:0]  appblk0_rdata_in,
  input  wire logic [`MRA_DW-1:0]  appblk1_rdata_in,
  input  wire logic [`MRA_DW-1:0]  appblk2_rdata_in,
  input  wire logic                appblk0_ready_low,
  input  wire logic                appblk1_ready_low,
  input  wire logic                appblk2_ready_low,
  input  wire logic                appblk0_irq_low,
  input  wire logic                appblk1_irq_low,
  input  wire logic                appblk2_irq_low
);
  mra_app_if app ();

  mra_pkg::mra_state_t st_q;
  mra_pkg::mra_state_t st_d;
  logic [`MRA_TMO_W-1:0] tmo_q;
  logic [`MRA_TMO_W-1:0] tmo_d;
  logic [`MRA_DW-1:0]    rdo_q;
  logic [`MRA_DW-1:0]    rdo_d;
  logic                  rdy_q;
  logic                  rdy_d;
  logic                  to_q;
  logic                  to_d;
  logic [`MRA_AW-1:0]    oa_q;
  logic [`MRA_AW-1:0]    oa_d;
  logic [`MRA_DW-1:0]    ow_q;
  logic [`MRA_DW-1:0]    ow_d;
  logic [`MRA_SW-1:0]    owr_q;
  logic [`MRA_SW-1:0]    owr_d;
  logic                  ord_q;
  logic                  ord_d;
  logic                  osel_q;
  logic                  osel_d;
  logic                  ack_q;
  logic                  ack_d;
  logic                  capt_go;
  logic                  irq_d;
  logic                  irq_q;
  logic                  csr_wr;
  logic [`MRA_DW-1:0]    csr_rd;
  logic [`MRA_DW-1:0]    evt_pend;

  function automatic logic is_app(input logic [`MRA_AW-1:0] a);
    return a[`MRA_APP_BIT];
  endfunction

  // Captures one word per request; ack held until request drops
  assign capt_go = ~capt_req_low & ~ack_q;

  assign csr_wr = (st_q == mra_pkg::MRA_CSR) & (host_wr_low != {`MRA_SW{1'b1}});

  mra_csr_bank u_csr
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .wr_en     (csr_wr),
    .idx       (host_addr_in[`MRA_CSR_IDX_W-1:0]),
    .byte_en   (~host_wr_low),
    .wdata     (host_wdata_in),
    .rdata     (csr_rd),
    .capt_en   (capt_go),
    .capt_data (capt_data_in),
    .evt_set   (core_event),
    .evt_pend  (evt_pend)
  );

  mra_app_mux u_mux
  (
    .sys_clk           (sys_clk),
    .srst              (srst),
    .clk_en            (clk_en),
    .m                 (app.mux),
    .app_addr          (app_addr),
    .app_wdata         (app_wdata),
    .app_wr_low        (app_wr_low),
    .app_rd_low        (app_rd_low),
    .app_sel_low       (app_sel_low),
    .appblk0_rdata_in  (appblk0_rdata_in),
    .appblk1_rdata_in  (appblk1_rdata_in),
    .appblk2_rdata_in  (appblk2_rdata_in),
    .appblk0_ready_low (appblk0_ready_low),
    .appblk1_ready_low (appblk1_ready_low),
    .appblk2_ready_low (appblk2_ready_low)
  );

  assign app.addr    = oa_q;
  assign app.wdata   = ow_q;
  assign app.wr_low  = owr_q;
  assign app.rd_low  = ord_q;
  assign app.sel_low = osel_q;

  // Access sequencer; app cycles are registered here and driven out on the app_* pins through u_mux
  always_comb
  begin
    st_d   = st_q;
    tmo_d  = tmo_q;
    rdo_d  = rdo_q;
    rdy_d  = 1'b0;
    to_d   = 1'b0;
    oa_d   = oa_q;
    ow_d   = ow_q;
    owr_d  = owr_q;
    ord_d  = ord_q;
    osel_d = osel_q;
    case (st_q)
      mra_pkg::MRA_IDLE:
      begin
        tmo_d = '0;
        if (!host_sel_low)
        begin
          if (is_app(host_addr_in))
          begin
            st_d   = mra_pkg::MRA_APP;
            oa_d   = host_addr_in;
            ow_d   = host_wdata_in;
            owr_d  = host_wr_low;
            ord_d  = host_rd_low;
            osel_d = `MRA_ONE_LOW;
          end
          else
            st_d = mra_pkg::MRA_CSR;
        end
      end
      mra_pkg::MRA_CSR:
      begin
        // Write lands this cycle; read data is combinational from the bank
        rdo_d = csr_rd;
        rdy_d = 1'b1;
        st_d  = mra_pkg::MRA_DONE;
      end
      mra_pkg::MRA_APP:
      begin
        tmo_d = tmo_q + 1'b1;
        if (app.ready)
        begin
          rdo_d  = app.rdata;
          rdy_d  = 1'b1;
          osel_d = `MRA_IDLE_HIGH;
          ord_d  = `MRA_IDLE_HIGH;
          owr_d  = {`MRA_SW{1'b1}};
          st_d   = mra_pkg::MRA_DONE;
        end
        else if (tmo_q == `MRA_TMO_W'(`MRA_TMO_CYC - 1))
        begin
          // A silent block must not hang the host
          rdo_d  = '0;
          rdy_d  = 1'b1;
          to_d   = 1'b1;
          osel_d = `MRA_IDLE_HIGH;
          ord_d  = `MRA_IDLE_HIGH;
          owr_d  = {`MRA_SW{1'b1}};
          st_d   = mra_pkg::MRA_DONE;
        end
      end
      mra_pkg::MRA_DONE:
      begin
        // Host drops select here; wait so one cycle is never taken twice
        st_d = host_sel_low ? mra_pkg::MRA_IDLE : mra_pkg::MRA_HOLD;
      end
      mra_pkg::MRA_HOLD:
      begin
        if (host_sel_low)
          st_d = mra_pkg::MRA_IDLE;
      end
      default:
      begin
        st_d = mra_pkg::MRA_IDLE;
      end
    endcase
  end

  always_comb
  begin
    ack_d = ~capt_req_low;
    irq_d = (|evt_pend) | ~appblk0_irq_low | ~appblk1_irq_low | ~appblk2_irq_low;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q   <= mra_pkg::MRA_IDLE;
      tmo_q  <= '0;
      rdo_q  <= '0;
      rdy_q  <= 1'b0;
      to_q   <= 1'b0;
      oa_q   <= '0;
      ow_q   <= '0;
      owr_q  <= {`MRA_SW{1'b1}};
      ord_q  <= `MRA_IDLE_HIGH;
      osel_q <= `MRA_IDLE_HIGH;
      ack_q  <= 1'b0;
      irq_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q   <= st_d;
      tmo_q  <= tmo_d;
      rdo_q  <= rdo_d;
      rdy_q  <= rdy_d;
      to_q   <= to_d;
      oa_q   <= oa_d;
      ow_q   <= ow_d;
      owr_q  <= owr_d;
      ord_q  <= ord_d;
      osel_q <= osel_d;
      ack_q  <= ack_d;
      irq_q  <= irq_d;
    end
  end

  assign host_rdata_out   = rdo_q;
  assign host_ready_low   = ~rdy_q;
  assign host_timeout_low = ~to_q;
  assign host_irq_low     = ~irq_q;
  assign capt_ack_low     = ~ack_q;
endmodule
`default_nettype wire

// >>> test/mra_mgmt_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mra_mgmt_monitor
(
  // Clock
  input wire logic        sys_clk,
  input wire logic        srst,
  // Host port
  input wire logic [21:0] host_addr_in,
  input wire logic [31:0] host_wdata_in,
  input wire logic        host_sel_low,
  input wire logic [3:0]  host_wr_low,
  input wire logic        host_rd_low,
  input wire logic        host_ready_low,
  input wire logic        host_timeout_low,
  input wire logic        host_irq_low,
  // Capture
  input wire logic        capt_req_low,
  input wire logic        capt_ack_low,
  // Outbound port
  input wire logic [21:0] app_addr,
  input wire logic [31:0] app_wdata,
  input wire logic [3:0]  app_wr_low,
  input wire logic        app_rd_low,
  input wire logic        app_sel_low,
  input wire logic        appblk0_ready_low,
  input wire logic        appblk1_irq_low
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_take;
    $fell(host_sel_low);
  endsequence
  sequence s_blk0_done;
    !app_sel_low && !appblk0_ready_low && app_addr[20:19] == 2'h0;
  endsequence
  property p_rdy_pulse;
    !host_ready_low |=> host_ready_low;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready low too long");
  property p_tmo_rdy;
    !host_timeout_low |-> !host_ready_low;
  endproperty
  a_tmo_rdy: assert property (p_tmo_rdy)
    else $error("timeout without ready");
  property p_csr_ans;
    s_take ##0 !host_addr_in[21] |=> host_ready_low ##1 !host_ready_low;
  endproperty
  a_csr_ans: assert property (p_csr_ans)
    else $error("register answer late");
  property p_app_start;
    s_take ##0 host_addr_in[21] |=> !app_sel_low && app_addr == $past(host_addr_in)
      && app_wdata == $past(host_wdata_in) && app_wr_low == $past(host_wr_low)
      && app_rd_low == $past(host_rd_low);
  endproperty
  a_app_start: assert property (p_app_start)
    else $error("outbound cycle wrong");
  property p_app_drop;
    s_blk0_done |-> ##[1:3] app_sel_low;
  endproperty
  a_app_drop: assert property (p_app_drop)
    else $error("outbound select held");
  property p_app_ans;
    s_blk0_done |-> ##[1:3] !host_ready_low;
  endproperty
  a_app_ans: assert property (p_app_ans)
    else $error("block answer not passed");
  property p_irq;
    !appblk1_irq_low [*2] |-> !host_irq_low;
  endproperty
  a_irq: assert property (p_irq)
    else $error("block interrupt lost");
  property p_capt;
    !capt_req_low [*2] |-> !capt_ack_low;
  endproperty
  a_capt: assert property (p_capt)
    else $error("capture not acknowledged");
  property p_capt_rel;
    capt_req_low [*2] |-> capt_ack_low;
  endproperty
  a_capt_rel: assert property (p_capt_rel)
    else $error("acknowledge without request");
endmodule
bind mra_mgmt_ports mra_mgmt_monitor mra_mgmt_monitor_i (.*);
`default_nettype wire

// >>> test/mra_blk_model.sv
`timescale 1ns/10ps
`default_nettype none
module mra_blk_model
(
  // Clock
  input wire logic         sys_clk,
  // Shared outbound pins
  input wire logic [21:0]  app_addr,
  input wire logic [31:0]  app_wdata,
  input wire logic [3:0]   app_wr_low,
  input wire logic         app_sel_low,
  // Per-block returns
  input wire logic [2:0]   irq_req,
  output logic [2:0][31:0] rdata,
  output logic [2:0]       ready_low,
  output logic [2:0]       irq_low
);
  logic [31:0] mem [3][4];
  logic [3:0]  wait_q;
  logic        done_q;
  logic [31:0] last_q;
  logic [1:0]  blk;
  assign blk = app_addr[20:19];
  assign irq_low = ~irq_req;
  initial
  begin
    ready_low = 3'h7;
    rdata = '0;
    done_q = 1'b0;
    wait_q = 4'h0;
    last_q = 32'h0;
  end
  // Block n waits 3n cycles; block 3 never answers
  // Plain always so the start values above may share these variables
  always @(posedge sys_clk)
  begin
    ready_low <= 3'h7;
    rdata <= {3{~last_q}};
    if (app_sel_low)
    begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end
    else if (!done_q && blk != 2'h3)
    begin
      if (wait_q == {2'h0, blk} * 4'h3)
      begin
        done_q <= 1'b1;
        ready_low[blk] <= 1'b0;
        if (app_wr_low != 4'hf)
        begin
          for (int b = 0; b < 4; b++)
            if (!app_wr_low[b])
              mem[blk][app_addr[1:0]][8*b+:8] <= app_wdata[8*b+:8];
        end
        else
        begin
          rdata[blk] <= mem[blk][app_addr[1:0]];
          last_q <= mem[blk][app_addr[1:0]];
        end
      end
      else
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk, srst, clk_en, host_sel_low, host_rd_low, capt_req_low;
  logic        host_ready_low, host_irq_low, host_timeout_low, capt_ack_low;
  logic        app_rd_low, app_sel_low, tmo_q;
  logic [3:0]  host_wr_low, app_wr_low;
  logic [21:0] host_addr_in, app_addr;
  logic [31:0] host_wdata_in, host_rdata_out, capt_data_in, core_event, app_wdata, rd_q;
  logic [2:0][31:0] blk_rdata;
  logic [2:0]  blk_ready, blk_irq, irq_req;
  int          error_cnt, check_count, cyc;
  mra_mgmt_ports mra_mgmt_ports_i (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out),
    .host_addr_in(host_addr_in), .host_sel_low(host_sel_low), .host_wr_low(host_wr_low),
    .host_rd_low(host_rd_low), .host_ready_low(host_ready_low),
    .host_irq_low(host_irq_low), .host_timeout_low(host_timeout_low),
    .capt_data_in(capt_data_in), .capt_req_low(capt_req_low), .capt_ack_low(capt_ack_low),
    .core_event(core_event), .app_addr(app_addr), .app_wdata(app_wdata),
    .app_wr_low(app_wr_low), .app_rd_low(app_rd_low), .app_sel_low(app_sel_low),
    .appblk0_rdata_in(blk_rdata[0]), .appblk1_rdata_in(blk_rdata[1]),
    .appblk2_rdata_in(blk_rdata[2]), .appblk0_ready_low(blk_ready[0]),
    .appblk1_ready_low(blk_ready[1]), .appblk2_ready_low(blk_ready[2]),
    .appblk0_irq_low(blk_irq[0]), .appblk1_irq_low(blk_irq[1]),
    .appblk2_irq_low(blk_irq[2]));
  mra_blk_model mra_blk_model_i (.sys_clk(sys_clk), .app_addr(app_addr),
    .app_wdata(app_wdata), .app_wr_low(app_wr_low), .app_sel_low(app_sel_low),
    .irq_req(irq_req), .rdata(blk_rdata), .ready_low(blk_ready), .irq_low(blk_irq));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Select drops at the edge after ready is seen
  task automatic host_cycle(input logic [21:0] a, input logic [3:0] wr, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    host_sel_low <= 1'b0;
    host_addr_in <= a;
    host_wr_low <= wr;
    host_rd_low <= ~&wr;
    host_wdata_in <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1 n++;
    end while (host_ready_low !== 1'b0 && n < 400);
    rd_q = host_rdata_out;
    tmo_q = host_timeout_low;
    check("ready seen", 32'h1, 32'(n < 400));
    @(posedge sys_clk);
    host_sel_low <= 1'b1;
    host_wr_low <= 4'hf;
    host_rd_low <= 1'b1;
  endtask
  task automatic t_csr();
    host_cycle(22'h2, 4'h0, 32'h11223344);
    host_cycle(22'h2, 4'ha, 32'haabbccdd);
    host_cycle(22'h2, 4'hf, 32'h0);
    check("csr bytes", 32'h11bb33dd, rd_q);
    check("csr timeout", 32'h1, 32'(tmo_q));
    $display("csr test done");
  endtask
  task automatic t_app();
    for (int b = 0; b < 3; b++)
      host_cycle({1'b1, 2'(b), 19'h1}, 4'h0, 32'hc0de0000 + b);
    host_cycle({1'b1, 2'h2, 19'h1}, 4'h7, 32'hffeeddcc);
    for (int b = 0; b < 3; b++)
    begin
      host_cycle({1'b1, 2'(b), 19'h1}, 4'hf, 32'h0);
      check("app read", b == 2 ? 32'hffde0002 : 32'hc0de0000 + b, rd_q);
    end
    $display("app test done");
  endtask
  task automatic t_tmo();
    host_cycle({1'b1, 2'h3, 19'h0}, 4'hf, 32'h0);
    check("timeout flag", 32'h0, 32'(tmo_q));
    check("timeout data", 32'h0, rd_q);
    $display("timeout test done");
  endtask
  task automatic t_irq();
    for (int b = 0; b < 3; b++)
    begin
      irq_req <= 3'h1 << b;
      tick(3);
      #1 check("block irq", 32'h0, 32'(host_irq_low));
      tick(1);
      irq_req <= 3'h0;
      tick(3);
      #1 check("irq idle", 32'h1, 32'(host_irq_low));
    end
    host_cycle(22'hd, 4'h0, 32'h1);
    tick(1);
    core_event <= 32'h2;
    tick(1);
    core_event <= 32'h0;
    tick(3);
    #1 check("masked event", 32'h1, 32'(host_irq_low));
    tick(1);
    core_event <= 32'h1;
    tick(1);
    core_event <= 32'h0;
    tick(3);
    #1 check("unmasked event", 32'h0, 32'(host_irq_low));
    host_cycle(22'he, 4'h0, 32'h1);
    host_cycle(22'he, 4'hf, 32'h0);
    check("pending", 32'h2, rd_q);
    #1 check("irq cleared", 32'h1, 32'(host_irq_low));
    $display("irq test done");
  endtask
  task automatic t_capt();
    tick(1);
    capt_data_in <= 32'h5a5a0f0f;
    capt_req_low <= 1'b0;
    tick(3);
    #1 check("capture ack", 32'h0, 32'(capt_ack_low));
    tick(1);
    capt_req_low <= 1'b1;
    tick(2);
    #1 check("ack release", 32'h1, 32'(capt_ack_low));
    host_cycle(22'hf, 4'hf, 32'h0);
    check("capture data", 32'h5a5a0f0f, rd_q);
    $display("capture test done");
  endtask
  initial
  begin
    srst = 1'b1;
    clk_en = 1'b1;
    host_sel_low = 1'b1;
    host_rd_low = 1'b1;
    host_wr_low = 4'hf;
    host_addr_in = 22'h0;
    host_wdata_in = 32'h0;
    capt_req_low = 1'b1;
    capt_data_in = 32'h0;
    core_event = 32'h0;
    irq_req = 3'h0;
    tick(6);
    srst <= 1'b0;
    t_csr();
    t_app();
    t_tmo();
    t_irq();
    t_capt();
    print_verdict();
  end
endmodule
`default_nettype wire
